/* File: logic/iisb_map.vh */
`ifndef IISB_MAP_VH
`define IISB_MAP_VH
// Setup packet buffer byte addresses
`define IISB_ADDR_REQ_TYPE   16'hFF28
`define IISB_ADDR_REQ_CODE   16'hFF29
`define IISB_ADDR_VALUE_A    16'hFF2A
`define IISB_ADDR_VALUE_B    16'hFF2B
`define IISB_ADDR_INDEX_A    16'hFF2C
`define IISB_ADDR_INDEX_B    16'hFF2D
`define IISB_ADDR_LENGTH_A   16'hFF2E
`define IISB_ADDR_LENGTH_B   16'hFF2F
`define IISB_SETUP_BASE      16'hFF28
`define IISB_SETUP_BYTES     4'h8
// Configuration byte address (no printed offset)
`define IISB_ADDR_EP_CONFIG  16'hFF48
// Configuration byte fields
`define IISB_BIT_ENABLE      7
`define IISB_BIT_ISO         6
`define IISB_BIT_OVF         5
`define IISB_SIZE_MSB        4
`define IISB_SIZE_LSB        0
`define IISB_CONFIG_RESET    8'h00
`define IISB_BYTE_RESET      8'h00
`endif

/* File: logic/iisb_setup_buffer.v */
`timescale 1ns/1ps
`default_nettype none
`include "iisb_map.vh"
module iisb_setup_buffer (
  // Clock and reset
  input  wire       clk_i,
  input  wire       sys_rst_i,
  input  wire       ce_i,
  // Setup stage byte stream
  input  wire       setup_start_i,
  input  wire       setup_byte_valid_i,
  input  wire [7:0] setup_byte_i,
  // Read port
  input  wire [2:0] rd_index_i,
  output wire [7:0] rd_byte_o,
  output wire       packet_done_o
);
  reg [7:0] byte_q [0:7];
  reg [3:0] wr_idx_q;
  reg       done_q;
  wire [3:0] wr_idx_d;
  wire       wr_en;

  // A fresh start restarts at byte zero even mid-packet
  assign wr_idx_d = setup_start_i ? 4'h0 : wr_idx_q;
  assign wr_en    = setup_byte_valid_i && (wr_idx_d < `IISB_SETUP_BYTES);

  // Bytes land in host order, so low byte of each field at lower address
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : g_byte
      always @(posedge clk_i or posedge sys_rst_i)
      begin
        if (sys_rst_i)
          byte_q[g] <= `IISB_BYTE_RESET;
        else if (ce_i && wr_en && (wr_idx_d[2:0] == g))
          byte_q[g] <= setup_byte_i;
      end
    end
  endgenerate

  always @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      wr_idx_q <= 4'h0;
      done_q   <= 1'b0;
    end
    else if (ce_i)
    begin
      // Extra bytes beyond eight are dropped
      if (wr_en)
        wr_idx_q <= wr_idx_d + 4'h1;
      else
        wr_idx_q <= wr_idx_d;
      done_q <= wr_en && (wr_idx_d == 4'h7);
    end
  end

  assign rd_byte_o     = byte_q[rd_index_i];
  assign packet_done_o = done_q;
endmodule // iisb_setup_buffer
`default_nettype wire

/* File: logic/iisb_top.v */
`timescale 1ns/1ps
`default_nettype none
`include "iisb_map.vh"
module iisb_top (
  // Clock, reset, enable
  input  wire        clk_i,
  input  wire        sys_rst_i,
  input  wire        ce_i,
  // Microcontroller memory port
  input  wire [15:0] mem_addr_i,
  input  wire        mem_wr_i,
  input  wire        mem_rd_i,
  input  wire [7:0]  mem_wdata_i,
  output reg  [7:0]  mem_rdata_o,
  output reg         mem_hit_o,
  // Buffer size byte from the endpoint descriptor
  input  wire [7:0]  buf_size_i,
  // Buffer manager events
  input  wire        buf_overflow_i,
  // Setup stage byte stream from the host side
  input  wire        setup_start_i,
  input  wire        setup_byte_valid_i,
  input  wire [7:0]  setup_byte_i,
  // Endpoint status to the transfer logic
  output reg         in_endpoint_enable_o,
  output reg         iso_active_o,
  output reg  [5:0]  sample_bytes_o,
  output reg  [10:0] circ_buf_len_o,
  output reg         overflow_flag_o,
  output reg         setup_ready_o
);
  // Configuration byte and its next value
  reg  [7:0]  cfg_q;
  reg  [7:0]  cfg_d;
  // Setup buffer read side
  wire [7:0]  setup_rd_byte;
  wire        setup_done;
  wire [15:0] setup_off;
  // Address decode
  reg         in_setup;
  wire        cfg_sel;
  wire        cfg_wr;
  wire        cfg_rd;
  wire        setup_rd;
  wire        len_hi_rd;
  // Overflow flag terms
  wire        ovf_event;
  wire        ovf_clear;
  wire        ovf_keep;
  // Next values of the registered outputs
  wire        enable_d;
  wire        iso_d;
  wire [5:0]  sample_d;
  wire [10:0] circ_len_d;
  reg  [7:0]  rdata_d;
  wire        hit_d;
  wire        ready_d;

  // One arm per byte keeps the packet map in one place
  always @*
  begin
    case (mem_addr_i)
      `IISB_ADDR_REQ_TYPE: in_setup = 1'b1;
      `IISB_ADDR_REQ_CODE: in_setup = 1'b1;
      `IISB_ADDR_VALUE_A:  in_setup = 1'b1;
      `IISB_ADDR_VALUE_B:  in_setup = 1'b1;
      `IISB_ADDR_INDEX_A:  in_setup = 1'b1;
      `IISB_ADDR_INDEX_B:  in_setup = 1'b1;
      `IISB_ADDR_LENGTH_A: in_setup = 1'b1;
      `IISB_ADDR_LENGTH_B: in_setup = 1'b1;
      default:             in_setup = 1'b0;
    endcase
  end

  // Buffer index is the byte offset from the packet base
  assign setup_off = mem_addr_i - `IISB_SETUP_BASE;
  assign cfg_sel   = (mem_addr_i == `IISB_ADDR_EP_CONFIG);
  assign cfg_wr    = mem_wr_i && cfg_sel;
  assign cfg_rd    = mem_rd_i && cfg_sel;
  // Packet bytes are read only; a write there only answers with a hit
  assign setup_rd  = mem_rd_i && in_setup;
  assign len_hi_rd = mem_rd_i && (mem_addr_i == `IISB_ADDR_LENGTH_B);

  // Packet bytes arrive from the host side in host order
  iisb_setup_buffer u_setup (
    .clk_i              (clk_i),
    .sys_rst_i          (sys_rst_i),
    .ce_i               (ce_i),
    .setup_start_i      (setup_start_i),
    .setup_byte_valid_i (setup_byte_valid_i),
    .setup_byte_i       (setup_byte_i),
    .rd_index_i         (setup_off[2:0]),
    .rd_byte_o          (setup_rd_byte),
    .packet_done_o      (setup_done)
  );

  // Events count only while the endpoint is live and isochronous
  assign ovf_event = buf_overflow_i && cfg_q[`IISB_BIT_ENABLE]
                     && cfg_q[`IISB_BIT_ISO];
  // A one written to the flag never sets it; only a zero clears it
  assign ovf_clear = cfg_wr && !mem_wdata_i[`IISB_BIT_OVF];
  assign ovf_keep  = cfg_q[`IISB_BIT_OVF] && !ovf_clear;

  always @*
  begin
    cfg_d = cfg_q;
    if (cfg_wr)
      cfg_d = mem_wdata_i;
    // Set wins over a same-cycle firmware clear
    cfg_d[`IISB_BIT_OVF] = ovf_event || ovf_keep;
  end

  // Status follows the next value, so a write shows one cycle later
  assign enable_d   = cfg_d[`IISB_BIT_ENABLE];
  // Non-iso use relies on firmware keeping bit 6 low
  assign iso_d      = cfg_d[`IISB_BIT_ENABLE] && cfg_d[`IISB_BIT_ISO];
  assign sample_d   = {1'b0, cfg_d[`IISB_SIZE_MSB:`IISB_SIZE_LSB]}
                      + 6'h01;
  // Size in 8-byte units, one ring rather than a pair of buffers
  assign circ_len_d = cfg_d[`IISB_BIT_ISO] ?
                      {buf_size_i, 3'b000} : 11'h000;

  always @*
  begin
    rdata_d = 8'h00;
    if (setup_rd)
      rdata_d = setup_rd_byte;
    else if (cfg_rd)
      rdata_d = cfg_q;
  end
  // Writes hit too, so firmware can tell a mapped read-only byte
  assign hit_d   = (mem_rd_i || mem_wr_i) && (in_setup || cfg_sel);
  // Set wins over the clearing read of the last length byte
  assign ready_d = setup_done || (setup_ready_o && !len_hi_rd);

  // Frozen with the rest while ce_i is low
  always @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      cfg_q <= `IISB_CONFIG_RESET;
    else if (ce_i)
      cfg_q <= cfg_d;
  end

  // Answer is registered and stands for the one cycle after the access
  always @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      mem_rdata_o <= 8'h00;
    else if (ce_i)
      mem_rdata_o <= rdata_d;
  end

  always @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      mem_hit_o <= 1'b0;
    else if (ce_i)
      mem_hit_o <= hit_d;
  end

  always @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      in_endpoint_enable_o <= 1'b0;
      iso_active_o         <= 1'b0;
    end
    else if (ce_i)
    begin
      in_endpoint_enable_o <= enable_d;
      iso_active_o         <= iso_d;
    end
  end

  // Reset value matches a zero size field
  always @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      sample_bytes_o <= 6'h01;
      circ_buf_len_o <= 11'h000;
    end
    else if (ce_i)
    begin
      sample_bytes_o <= sample_d;
      circ_buf_len_o <= circ_len_d;
    end
  end

  // Flag feeds status only, never the transfer path
  always @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      overflow_flag_o <= 1'b0;
    else if (ce_i)
      overflow_flag_o <= cfg_d[`IISB_BIT_OVF];
  end

  always @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      setup_ready_o <= 1'b0;
    else if (ce_i)
      setup_ready_o <= ready_d;
  end
endmodule // iisb_top
`default_nettype wire

/* File: verification/iisb_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module iisb_host_model (
  input  wire logic       clk_i,
  input  wire logic       go_i,
  input  wire logic [63:0] pkt_i,
  output var logic        start_o = 1'b0,
  output var logic        valid_o = 1'b0,
  output var logic [7:0]  byte_o = 8'h00
);
  int n = 8;
  always @(posedge clk_i)
  begin
    // Start request is taken at the edge, the bytes follow just after it
    if (go_i)
      n = 0;
    #1;
    start_o = n == 0;
    valid_o = n < 8;
    // Idle data toggles so a stale byte is never mistaken for a fresh one
    byte_o = n < 8 ? pkt_i[8*n +: 8] : ~byte_o;
    if (n < 8) n++;
  end
endmodule // iisb_host_model
`default_nettype wire

/* File: verification/iisb_top_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module iisb_top_checker (
  input wire logic        clk_i,
  input wire logic        sys_rst_i,
  input wire logic        ce_i,
  input wire logic [15:0] mem_addr_i,
  input wire logic        mem_wr_i,
  input wire logic        mem_rd_i,
  input wire logic [7:0]  mem_wdata_i,
  input wire logic [7:0]  mem_rdata_o,
  input wire logic        mem_hit_o,
  input wire logic        buf_overflow_i,
  input wire logic        setup_start_i,
  input wire logic        setup_byte_valid_i,
  input wire logic        in_endpoint_enable_o,
  input wire logic        iso_active_o,
  input wire logic [5:0]  sample_bytes_o,
  input wire logic        overflow_flag_o,
  input wire logic        setup_ready_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  wire cfg_wr = ce_i && mem_wr_i && mem_addr_i == 16'hFF48;
  sequence eight_bytes;
    ce_i && setup_start_i && setup_byte_valid_i
    ##1 (ce_i && setup_byte_valid_i && !setup_start_i) [*7];
  endsequence
  a_enable_follows: assert property (cfg_wr |=>
    in_endpoint_enable_o == $past(mem_wdata_i[7])) else $error("enable");
  a_iso_mode: assert property (cfg_wr |=>
    iso_active_o == $past(mem_wdata_i[7] && mem_wdata_i[6])) else $error("iso");
  a_sample_size: assert property (cfg_wr |=>
    sample_bytes_o == $past(mem_wdata_i[4:0]) + 6'h01) else $error("size");
  a_ovf_sets: assert property (ce_i && buf_overflow_i && iso_active_o
    |=> overflow_flag_o) else $error("ovf set");
  a_ovf_sticky: assert property (overflow_flag_o && !cfg_wr
    |=> overflow_flag_o) else $error("ovf cleared");
  a_ovf_passive: assert property ($rose(overflow_flag_o) && !$past(mem_wr_i)
    |-> $stable(in_endpoint_enable_o) && $stable(sample_bytes_o)) else $error("ovf");
  a_setup_ready: assert property (eight_bytes |=> ##1 setup_ready_o)
    else $error("ready");
  a_miss_quiet: assert property (ce_i && mem_rd_i && mem_addr_i == 16'hFF50
    |=> !mem_hit_o && mem_rdata_o == 8'h00) else $error("miss");
endmodule // iisb_top_checker
`default_nettype wire

/* File: verification/iso_in_endpoint_setup_buffer_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a,b) begin n_checks++; if ((a) !== (b)) begin num_errors++; \
  $display("MISMATCH %0t got %h exp %h", $time, a, b); end end
module iso_in_endpoint_setup_buffer_bench;
  logic clk_i = 0, sys_rst_i = 1, ce_i = 1, mem_wr_i = 0, mem_rd_i = 0;
  logic buf_overflow_i = 0, go = 0, mem_hit_o, in_endpoint_enable_o;
  logic iso_active_o, overflow_flag_o, setup_ready_o, setup_start_i;
  logic setup_byte_valid_i;
  logic [15:0] mem_addr_i = 16'h0000;
  logic [7:0] mem_wdata_i = 8'h00, buf_size_i = 8'h18, mem_rdata_o, setup_byte_i;
  logic [5:0] sample_bytes_o;
  logic [10:0] circ_buf_len_o;
  logic [63:0] pkt = 64'h0040_0000_0100_0680;
  int num_errors = 0, n_checks = 0;
  iisb_top u_iisb_top (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
    .mem_addr_i(mem_addr_i), .mem_wr_i(mem_wr_i), .mem_rd_i(mem_rd_i),
    .mem_wdata_i(mem_wdata_i), .mem_rdata_o(mem_rdata_o),
    .mem_hit_o(mem_hit_o), .buf_size_i(buf_size_i),
    .buf_overflow_i(buf_overflow_i), .setup_start_i(setup_start_i),
    .setup_byte_valid_i(setup_byte_valid_i), .setup_byte_i(setup_byte_i),
    .in_endpoint_enable_o(in_endpoint_enable_o), .iso_active_o(iso_active_o),
    .sample_bytes_o(sample_bytes_o), .circ_buf_len_o(circ_buf_len_o),
    .overflow_flag_o(overflow_flag_o), .setup_ready_o(setup_ready_o));
  iisb_host_model u_host (.clk_i(clk_i), .go_i(go), .pkt_i(pkt),
    .start_o(setup_start_i), .valid_o(setup_byte_valid_i), .byte_o(setup_byte_i));
  always #2 clk_i = ~clk_i;
  task automatic acc(input logic [15:0] a, input logic w, input logic [7:0] d);
    @(posedge clk_i);
    #1 mem_addr_i = a;
    mem_wr_i = w;
    mem_rd_i = !w;
    mem_wdata_i = d;
    @(posedge clk_i);
    #1 mem_wr_i = 0;
    mem_rd_i = 0;
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    #20000;
    num_errors++;
    complete_run;
  end
  initial
  begin
    repeat (6) @(posedge clk_i);
    #1 sys_rst_i = 0;
    acc(16'hFF48, 1, 8'hC3);
    `CHK(({in_endpoint_enable_o, iso_active_o, sample_bytes_o}), 8'hC4)
    `CHK(circ_buf_len_o, 11'h0C0)
    acc(16'hFF48, 1, 8'h9F);
    `CHK(({in_endpoint_enable_o, iso_active_o, sample_bytes_o}), 8'hA0)
    `CHK(circ_buf_len_o, 11'h000)
    acc(16'hFF48, 1, 8'h5F);
    `CHK(({in_endpoint_enable_o, iso_active_o, sample_bytes_o}), 8'h20)
    acc(16'hFF48, 1, 8'hE3);
    `CHK(overflow_flag_o, 1'b0)
    @(posedge clk_i);
    #1 buf_overflow_i = 1;
    @(posedge clk_i);
    #1 buf_overflow_i = 0;
    `CHK(({overflow_flag_o, in_endpoint_enable_o, sample_bytes_o}), 8'hC4)
    acc(16'hFF48, 1, 8'hE3);
    `CHK(overflow_flag_o, 1'b1)
    acc(16'hFF48, 0, 8'h00);
    `CHK(mem_rdata_o, 8'hE3)
    acc(16'hFF48, 1, 8'hC3);
    `CHK(overflow_flag_o, 1'b0)
    go = 1;
    @(posedge clk_i);
    #1 go = 0;
    for (int i = 0; i < 20 && setup_ready_o !== 1'b1; i++)
    begin
      @(posedge clk_i);
      #1;
    end
    `CHK(setup_ready_o, 1'b1)
    acc(16'hFF28, 1, 8'h55);
    for (int i = 0; i < 8; i++)
    begin
      acc(16'hFF28 + 16'(i), 0, 8'h00);
      `CHK(({mem_hit_o, mem_rdata_o}), ({1'b1, pkt[8*i +: 8]}))
    end
    `CHK(setup_ready_o, 1'b0)
    acc(16'hFF50, 0, 8'h00);
    `CHK(({mem_hit_o, mem_rdata_o}), 9'h000)
    acc(16'hFF48, 1, 8'h83);
    buf_overflow_i = 1;
    @(posedge clk_i);
    #1 buf_overflow_i = 0;
    `CHK(overflow_flag_o, 1'b0)
    ce_i = 0;
    acc(16'hFF48, 1, 8'h00);
    `CHK(({mem_hit_o, in_endpoint_enable_o}), 2'b01)
    ce_i = 1;
    sys_rst_i = 1;
    @(posedge clk_i);
    #1 sys_rst_i = 0;
    `CHK(({in_endpoint_enable_o, sample_bytes_o}), 7'h01)
    complete_run;
  end
endmodule // iso_in_endpoint_setup_buffer_bench
bind iisb_top iisb_top_checker u_iisb_top_checker (.clk_i(clk_i),
  .sys_rst_i(sys_rst_i), .ce_i(ce_i), .mem_addr_i(mem_addr_i),
  .mem_wr_i(mem_wr_i), .mem_rd_i(mem_rd_i), .mem_wdata_i(mem_wdata_i),
  .mem_rdata_o(mem_rdata_o), .mem_hit_o(mem_hit_o),
  .buf_overflow_i(buf_overflow_i), .setup_start_i(setup_start_i),
  .setup_byte_valid_i(setup_byte_valid_i),
  .in_endpoint_enable_o(in_endpoint_enable_o), .iso_active_o(iso_active_o),
  .sample_bytes_o(sample_bytes_o), .overflow_flag_o(overflow_flag_o),
  .setup_ready_o(setup_ready_o));
`default_nettype wire
